// ---- urx_defines.svh ----
// Constants for the receive-command status encoder: field positions, codes and reset values.
// Assumes inclusion by bare name from design files that need the register map.
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

// Wishbone register byte offsets.
`define URX_OFS_CTRL      4'h0
`define URX_OFS_RISE_EN   4'h4
`define URX_OFS_FALL_EN   4'h8
`define URX_OFS_STATUS    4'hC

// Control register fields.
`define URX_CTRL_DP_PD     0
`define URX_CTRL_DM_PD     1
`define URX_CTRL_TERM      2
`define URX_CTRL_XCVR_LO   3
`define URX_CTRL_XCVR_HI   4
`define URX_CTRL_OPM_LO    5
`define URX_CTRL_OPM_HI    6
`define URX_CTRL_FLT_INV   7
`define URX_CTRL_EXT_SEL   8
`define URX_CTRL_FLT_BYP   9
`define URX_CTRL_SW_ON     10
`define URX_CTRL_W         11

// Interrupt-enable bit positions (same in rise and fall registers).
`define URX_IE_AVLD        0
`define URX_IE_SVLD        1
`define URX_IE_SEND        2
`define URX_IE_DISC        3
`define URX_IE_W           4

// Reset values.
`define URX_CTRL_RST       11'h000
`define URX_IE_RST         4'h0

`endif

// ---- urx_line_state.sv ----
// Combinational line state encoder for peripheral- and host-facing ports.
// Assumes synchronised analogue front-end levels and current control settings.
`timescale 1ns/1ps
module urx_line_state
(
    // Configuration.
    input  wire logic       host_i,
    input  wire logic [1:0] xcvr_i,
    input  wire logic       term_i,
    input  wire logic [1:0] opmode_i,
    // Front-end levels.
    input  wire logic       dp_i,
    input  wire logic       dm_i,
    input  wire logic       squelch_i,
    input  wire logic       hs_diff_i,
    // Encoded line state.
    output logic      [1:0] ls_o
);

    logic chirp;

    // Chirp reading differs by orientation: termination on a peripheral, opmode on a host.
    always_comb
    begin
        chirp = host_i ? (opmode_i == 2'h2) : term_i;
        ls_o  = {dm_i, dp_i};                          // Pin order unless xcvr_i selects high speed (2'h0).
        if (xcvr_i == 2'h0)
        begin
            if (squelch_i)
                ls_o = 2'h0;                           // Squelch.
            else if (chirp && !hs_diff_i)
                ls_o = 2'h2;                           // Chirp, low output.
            else
                ls_o = 2'h1;                           // Inactive squelch or chirp high.
        end
    end

endmodule

// ---- urx_link_model.sv ----
// Behavioural link controller that takes status commands after a settable stall.
// Assumes the encoder holds valid until it sees ready high; the byte is taken as it stands at acceptance.
`timescale 1ns/1ps
module urx_link_model
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Command port.
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [1:0]  stall_i,
    output logic             cmd_ready_o,
    // What the link has seen.
    output logic      [7:0]  last_o,
    output logic      [15:0] count_o
);
    // ------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------
    logic [1:0] wait_r;

    // A slow link is as legal as a prompt one, so ready rises stall_i cycles after valid is first seen.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmd_ready_o <= 1'h0;
            wait_r      <= 2'h0;
            last_o      <= 8'h00;
            count_o     <= 16'h0000;
        end
        else if (cmd_valid_i && cmd_ready_o)
        begin
            cmd_ready_o <= 1'h0;
            wait_r      <= 2'h0;
            last_o      <= cmd_i;
            count_o     <= count_o + 16'h0001;
        end
        else if (cmd_valid_i)
        begin
            cmd_ready_o <= wait_r == stall_i;
            wait_r      <= (wait_r == stall_i) ? wait_r : wait_r + 2'h1;
        end
    end
endmodule

// ---- urx_pkg.sv ----
// Types shared by the receive-command status encoder.
// Assumes nothing beyond a SystemVerilog compiler.
package urx_pkg;

    typedef enum logic [1:0]
    {
        URX_EV_IDLE   = 2'h0,
        URX_EV_ACTIVE = 2'h1,
        URX_EV_DISC   = 2'h2,
        URX_EV_ERROR  = 2'h3
    } urx_event_e;

    typedef enum logic [2:0]
    {
        URX_ST_IDLE = 3'h1,
        URX_ST_SEND = 3'h2,
        URX_ST_HOLD = 3'h4
    } urx_state_e;

endpackage

// ---- urx_status_encoder.sv ----
// Receive-command status encoder: builds the status byte sent to the link controller.
// Assumes front-end levels arrive asynchronously and registers are written over Wishbone.
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "urx_defines.svh"

// What this block does
// - Pick peripheral or host line state codes from the pull-down settings.
// - Peripheral full speed: SE0, J, K, SE1 as 00, 01, 10, 11.
// - Peripheral high speed and chirp: squelch 00, inactive squelch 01, chirp low 10.
// - Host full speed SE0,J,K,SE1; low speed SE0,K,J,SE1 as 00..11.
// - Host high speed squelch 00, else 01; chirp gives 01 or 10.
// - Low-speed peripheral with minus-line pull-up is not supported.
// - Supply indicator changes send a command only when the matching edge is enabled.
// - Supply field: below end 00, between 01, session valid 10, A-valid 11.
// - Event field: idle 00, active 01, active with error 11, disconnect 10.
// - The supply switch output drives the external charge pump.
// - Receive active is signalled by a command with the active event code.
// - On receive error drop the data strobe and send the error event.
// - Disconnect is valid in host mode only; each enabled change sends a command.
module urx_status_encoder
    import urx_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Front-end levels from the pins and analogue comparators.
    input  wire logic        dp_i,
    input  wire logic        dm_i,
    input  wire logic        squelch_i,
    input  wire logic        hs_diff_i,
    input  wire logic        sess_end_i,
    input  wire logic        sess_vld_i,
    input  wire logic        a_vld_i,
    input  wire logic        fault_i,
    input  wire logic        id_i,
    input  wire logic        disc_i,
    // Receive path events, same clock.
    input  wire logic        rx_active_i,
    input  wire logic        rx_error_i,
    input  wire logic        rx_data_valid_i,
    // Link side.
    input  wire logic        cmd_ready_i,
    output logic             cmd_valid_o,
    output logic      [7:0]  cmd_o,
    output logic             rx_nxt_o,
    output logic             supply_switch_output_o
);

    // ------------------------------------------------------------------
    // Reset and input synchronisation
    // ------------------------------------------------------------------
    logic              rst_meta_r;
    logic              rstn_r;
    logic [9:0]        pins_s;
    logic              dp_s;
    logic              dm_s;
    logic              sq_s;
    logic              hsd_s;
    logic              send_s;
    logic              svld_s;
    logic              avld_raw_s;
    logic              flt_s;
    logic              id_s;
    logic              disc_s;

    // Reset releases through two flops so that no flop sees a ragged edge.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_r <= 1'b0;
            rstn_r     <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rstn_r     <= rst_meta_r;
        end
    end

    urx_sync #(.W(10)) u_sync
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_r),
        .ce_i   (ce_i),
        .d_i    ({dp_i, dm_i, squelch_i, hs_diff_i, sess_end_i,
                  sess_vld_i, a_vld_i, fault_i, id_i, disc_i}),
        .q_o    (pins_s)
    );

    assign {dp_s, dm_s, sq_s, hsd_s, send_s, svld_s, avld_raw_s, flt_s, id_s, disc_s} = pins_s;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [`URX_CTRL_W-1:0] interface_control_reg_r;
    logic [`URX_IE_W-1:0]   rising_irq_enable_reg_r;
    logic [`URX_IE_W-1:0]   falling_irq_enable_reg_r;
    logic                   wb_req;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Writes land only on the low byte lanes the registers use.
    always_ff @(posedge clk_i or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            interface_control_reg_r  <= `URX_CTRL_RST;
            rising_irq_enable_reg_r  <= `URX_IE_RST;
            falling_irq_enable_reg_r <= `URX_IE_RST;
        end
        else if (ce_i && wb_req && wb_we_i)
        begin
            unique case (wb_adr_i)
                `URX_OFS_CTRL:
                begin
                    if (wb_sel_i[0])
                        interface_control_reg_r[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        interface_control_reg_r[`URX_CTRL_W-1:8] <= wb_dat_i[`URX_CTRL_W-1:8];
                end
                `URX_OFS_RISE_EN:
                    if (wb_sel_i[0])
                        rising_irq_enable_reg_r <= wb_dat_i[`URX_IE_W-1:0];
                `URX_OFS_FALL_EN:
                    if (wb_sel_i[0])
                        falling_irq_enable_reg_r <= wb_dat_i[`URX_IE_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status field construction
    // ------------------------------------------------------------------
    logic       host_mode;
    logic       avld_eff;
    logic [1:0] ls;
    logic [1:0] vbus;
    logic [1:0] ev;
    logic [3:0] ind;

    // Both pull-downs set means host-facing; anything else uses the peripheral set.
    assign host_mode = interface_control_reg_r[`URX_CTRL_DP_PD]
                       && interface_control_reg_r[`URX_CTRL_DM_PD];

    urx_line_state u_ls
    (
        .host_i    (host_mode),
        .xcvr_i    (interface_control_reg_r[`URX_CTRL_XCVR_HI:`URX_CTRL_XCVR_LO]),
        .term_i    (interface_control_reg_r[`URX_CTRL_TERM]),
        .opmode_i  (interface_control_reg_r[`URX_CTRL_OPM_HI:`URX_CTRL_OPM_LO]),
        .dp_i      (dp_s),
        .dm_i      (dm_s),
        .squelch_i (sq_s),
        .hs_diff_i (hsd_s),
        .ls_o      (ls)
    );

    // External fault may replace the A-valid comparator, qualified unless bypassed.
    always_comb
    begin
        avld_eff = avld_raw_s;
        if (interface_control_reg_r[`URX_CTRL_EXT_SEL])
        begin
            avld_eff = flt_s ^ interface_control_reg_r[`URX_CTRL_FLT_INV];
            if (!interface_control_reg_r[`URX_CTRL_FLT_BYP])
                avld_eff = avld_eff && avld_raw_s;
        end
    end

    // Supply state is a priority encoding of the comparators.
    always_comb
    begin
        if (avld_eff)
            vbus = 2'h3;
        else if (svld_s)
            vbus = 2'h2;
        else if (!send_s)
            vbus = 2'h1;
        else
            vbus = 2'h0;
    end

    // Receive activity wins over disconnect, and disconnect is only meaningful as host.
    always_comb
    begin
        if (rx_active_i && rx_error_i)
            ev = URX_EV_ERROR;
        else if (rx_active_i)
            ev = URX_EV_ACTIVE;
        else if (host_mode && disc_s)
            ev = URX_EV_DISC;
        else
            ev = URX_EV_IDLE;
    end

    assign ind = {host_mode && disc_s, send_s, svld_s, avld_eff};

    // ------------------------------------------------------------------
    // Change detection and command sender
    // ------------------------------------------------------------------
    logic [3:0]  ind_prev_r;
    logic [1:0]  ls_prev_r;
    logic [1:0]  ev_prev_r;
    logic [3:0]  ind_hit;
    logic        trig;
    logic        pend_r;
    urx_state_e  state_r;

    // Only enabled edges of the indicators request a command; line and event always do.
    assign ind_hit = (ind & ~ind_prev_r & rising_irq_enable_reg_r)
                   | (~ind & ind_prev_r & falling_irq_enable_reg_r);
    assign trig    = (|ind_hit) || (ls != ls_prev_r) || (ev != ev_prev_r);

    always_ff @(posedge clk_i or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            ind_prev_r <= '0;
            ls_prev_r  <= '0;
            ev_prev_r  <= '0;
        end
        else if (ce_i)
        begin
            ind_prev_r <= ind;
            ls_prev_r  <= ls;
            ev_prev_r  <= ev;
        end
    end

    // A new change during an outstanding command is kept; pend_r is set in SEND and HOLD and cleared only in IDLE.
    always_ff @(posedge clk_i or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            pend_r      <= 1'b0;
            state_r     <= URX_ST_IDLE;
            cmd_valid_o <= 1'b0;
            cmd_o       <= 8'h00;
        end
        else if (ce_i)
        begin
            unique case (state_r)
                URX_ST_IDLE:
                begin
                    if (trig || pend_r)
                    begin
                        state_r     <= URX_ST_SEND;
                        cmd_valid_o <= 1'b1;
                        pend_r      <= 1'b0;
                        cmd_o       <= {1'b0, id_s, ev, vbus, ls};
                    end
                end
                URX_ST_SEND:
                begin
                    if (trig)
                        pend_r <= 1'b1;
                    cmd_o <= {1'b0, id_s, ev, vbus, ls};
                    if (cmd_ready_i)
                    begin
                        state_r     <= URX_ST_HOLD;
                        cmd_valid_o <= 1'b0;
                    end
                end
                URX_ST_HOLD:
                begin
                    if (trig)
                        pend_r <= 1'b1;
                    state_r <= URX_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs: data strobe, supply switch and bus answer
    // ------------------------------------------------------------------

    // A receive error drops the data strobe on the next clock.
    always_ff @(posedge clk_i or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            rx_nxt_o               <= 1'b0;
            supply_switch_output_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rx_nxt_o               <= rx_data_valid_i && rx_active_i && !rx_error_i;
            supply_switch_output_o <= interface_control_reg_r[`URX_CTRL_SW_ON];
        end
    end

    // One wait-free answer per request; unmapped offsets read zero and ignore writes.
    always_ff @(posedge clk_i or negedge rstn_r)
    begin
        if (!rstn_r)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    `URX_OFS_CTRL:    wb_dat_o <= {21'h0, interface_control_reg_r};
                    `URX_OFS_RISE_EN: wb_dat_o <= {28'h0, rising_irq_enable_reg_r};
                    `URX_OFS_FALL_EN: wb_dat_o <= {28'h0, falling_irq_enable_reg_r};
                    `URX_OFS_STATUS:  wb_dat_o <= {20'h0, ind, 1'b0, id_s, ev, vbus, ls};
                    default:          ;
                endcase
            end
        end
    end

endmodule

// ---- urx_status_encoder_props.sv ----
// Checker for the encoder's bus, command and receive-strobe ports.
// Assumes it is bound to the top module and runs on its single clock.
`timescale 1ns/1ps
module urx_status_encoder_props
(
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // Wishbone side.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // Receive path and link side.
    input wire logic        rx_active_i,
    input wire logic        rx_error_i,
    input wire logic        rx_data_valid_i,
    input wire logic        cmd_ready_i,
    input wire logic        cmd_valid_o,
    input wire logic [7:0]  cmd_o,
    input wire logic        rx_nxt_o,
    input wire logic        supply_switch_output_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Helper terms for the bus and receive checks.
    wire req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire act_w = rx_active_i && !rx_error_i;
    wire err_w = rx_active_i && rx_error_i;

    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_SWITCH_WRITE: assert property (req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1]
        |-> ##2 supply_switch_output_o == $past(wb_dat_i[10], 2))
        else $error("supply switch does not follow the written bit");
    AST_VALID_HOLD: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o)
        else $error("command dropped before the link took it");
    AST_VALID_GAP: assert property (cmd_valid_o && cmd_ready_i |=> !cmd_valid_o [*2])
        else $error("command raised again too soon after acceptance");
    AST_ERR_EVENT: assert property (cmd_valid_o && $past(err_w) && $past(err_w, 2)
        |-> cmd_o[5:4] == 2'h3)
        else $error("receive error not reported in the event field");
    AST_ACT_EVENT: assert property (cmd_valid_o && $past(act_w) && $past(act_w, 2)
        |-> cmd_o[5:4] == 2'h1)
        else $error("receive active not reported in the event field");
    AST_NXT_RISE: assert property (rx_data_valid_i && act_w |=> rx_nxt_o)
        else $error("data strobe missing while receiving");
    AST_NXT_ERR: assert property (rx_error_i |=> !rx_nxt_o)
        else $error("data strobe kept during a receive error");
    AST_TOP_BIT: assert property (cmd_valid_o |-> cmd_o[7] == 1'h0)
        else $error("spare command bit set");

    COV_ACCEPT: cover property (cmd_valid_o && cmd_ready_i);
    COV_ERROR: cover property (cmd_valid_o && cmd_o[5:4] == 2'h3);
    COV_SWITCH: cover property (wb_ack_o && supply_switch_output_o);
endmodule

bind urx_status_encoder urx_status_encoder_props urx_status_encoder_props_inst
(
    .clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .rx_active_i, .rx_error_i, .rx_data_valid_i, .cmd_ready_i, .cmd_valid_o,
    .cmd_o, .rx_nxt_o, .supply_switch_output_o
);

// ---- urx_status_encoder_test.sv ----
// Self-checking bench: a behavioural model of the status byte is compared with the encoder.
// Assumes the link model and the checker are compiled with it.
`timescale 1ns/1ps
`include "urx_defines.svh"
module urx_status_encoder_test;
    // ------------------------------------------------------------
    // Signals, instances and helpers
    // ------------------------------------------------------------
    logic        clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dp_i, dm_i, squelch_i;
    logic        hs_diff_i, fault_i, id_i, disc_i, rx_active_i, rx_error_i, rx_data_valid_i;
    logic        cmd_ready_i, cmd_valid_o, rx_nxt_o, supply_switch_output_o;
    wire logic   sess_end_i, sess_vld_i, a_vld_i;
    logic [1:0]  stall;
    logic [2:0]  ind;
    logic [3:0]  wb_adr_i;
    logic [7:0]  cmd_o, link_last;
    logic [10:0] ctrl_m, c;
    logic [15:0] link_cnt;
    logic [31:0] wb_dat_i, wb_dat_o, rd, r;
    int          n_mismatch, tests_run, seed, base, m;

    assign {sess_end_i, sess_vld_i, a_vld_i} = ind;

    urx_status_encoder urx_status_encoder_inst
    (
        .clk_i, .rstn_i, .ce_i(1'h1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .dp_i, .dm_i, .squelch_i,
        .hs_diff_i, .sess_end_i, .sess_vld_i, .a_vld_i, .fault_i, .id_i, .disc_i,
        .rx_active_i, .rx_error_i, .rx_data_valid_i, .cmd_ready_i, .cmd_valid_o, .cmd_o,
        .rx_nxt_o, .supply_switch_output_o
    );

    urx_link_model urx_link_model_inst
    (
        .clk_i, .rstn_i, .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o), .stall_i(stall),
        .cmd_ready_o(cmd_ready_i), .last_o(link_last), .count_o(link_cnt)
    );

    // Free-running 10 MHz clock.
    initial
    begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end

    // Every comparison is counted; a mismatch is reported at once.
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        check_val(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Classic single cycle: hold everything until ack is sampled, then release.
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        check_flag("bus ack", 1'h1, wb_ack_o);
    endtask

    task automatic set_ctrl(input logic [10:0] v);
        ctrl_m = v;
        wb_xfer(1'h1, `URX_OFS_CTRL, {21'h0, v}, rd);
    endtask

    // Expected status byte from the current settings and pin levels.
    function automatic logic [7:0] exp_byte();
        logic       host, a_eff;
        logic [1:0] ls, vb, ev;
        host = ctrl_m[0] & ctrl_m[1];
        if (ctrl_m[4:3] != 2'h0)
            ls = {dm_i, dp_i};
        else if (squelch_i)
            ls = 2'h0;
        else if (host ? ctrl_m[6:5] == 2'h2 : ctrl_m[2])
            ls = hs_diff_i ? 2'h1 : 2'h2;
        else
            ls = 2'h1;
        a_eff = ctrl_m[8] ? (fault_i ^ ctrl_m[7]) & (ctrl_m[9] | a_vld_i) : a_vld_i;
        vb = a_eff ? 2'h3 : sess_vld_i ? 2'h2 : sess_end_i ? 2'h0 : 2'h1;
        ev = (rx_active_i & rx_error_i) ? 2'h3 : rx_active_i ? 2'h1 :
             (host & disc_i) ? 2'h2 : 2'h0;
        return {1'h0, id_i, ev, vb, ls};
    endfunction

    // Settle, then compare the status register and the link's last command.
    task automatic settle_check();
        repeat (16) @(posedge clk_i);
        wb_xfer(1'h0, `URX_OFS_STATUS, 32'h0, rd);
        check_val("status byte", {24'h0, exp_byte()}, {24'h0, rd[7:0]});
        check_val("link byte", {24'h0, exp_byte() & 8'h33}, {24'h0, link_last & 8'h33});
    endtask

    // Move one indicator; count the commands taken since base.
    task automatic edge_step(input int b, input logic v, input int add);
        ind[b] <= v;
        repeat (16) @(posedge clk_i);
        check_val("command count", 32'(base + add), {16'h0, link_cnt});
    endtask

    // Watchdog: the tests need under 3,000 cycles, so 20,000 means a hang.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("BAD watchdog expected finish seen hang");
        give_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, dp_i, dm_i, squelch_i, hs_diff_i} = 8'h00;
        {fault_i, id_i, disc_i, rx_active_i, rx_error_i, rx_data_valid_i} = 6'h00;
        {stall, ind, wb_adr_i, wb_dat_i, ctrl_m, c} = '0;
        n_mismatch = 0;
        tests_run = 0;
        seed = 32'hAA9F;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 3; i++)
        begin
            wb_xfer(1'h0, 4'(4 * i), 32'h0, rd);
            check_val("reset value", (i == 0) ? {21'h0, `URX_CTRL_RST} : {28'h0, `URX_IE_RST}, rd);
        end
        wb_xfer(1'h0, 4'h2, 32'h0, rd);
        check_val("unmapped read", 32'h0, rd);
        wb_xfer(1'h1, `URX_OFS_RISE_EN, 32'hFFFF_FFFF, rd);
        wb_xfer(1'h0, `URX_OFS_RISE_EN, 32'h0, rd);
        check_val("rise enable width", 32'hF, rd);
        wb_xfer(1'h1, `URX_OFS_RISE_EN, 32'h8, rd);
        for (int i = 1; i >= 0; i--)
        begin
            set_ctrl(11'(i << 10));
            @(posedge clk_i);
            check_flag("supply switch", 1'(i), supply_switch_output_o);
        end
        $display("test registers done");
        // Random legal modes and levels; mode 4 covers host high speed and chirp.
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            m = r[31:29] % 5;
            c = r[10:0];
            c[1:0] = (m > 2) ? 2'h3 : 2'h0;
            c[2] = (m == 0 || m == 2 || m == 3);
            c[4:3] = (m == 0) ? {r[11], 1'h1} : 2'h0;
            c[4:3] = (m == 3) ? ((r[12:11] == 2'h0) ? 2'h2 : r[12:11]) : c[4:3];
            set_ctrl(c);
            {dp_i, dm_i, squelch_i, hs_diff_i, id_i, fault_i} <= r[18:13];
            ind <= {r[20:19] == 2'h0, r[20], r[20:19] == 2'h3};
            stall <= r[22:21];
            settle_check();
        end
        $display("test line and supply fields done");
        for (int i = 0; i < 16; i++)
        begin
            set_ctrl(i[3] ? 11'h00F : 11'h00C);
            {disc_i, rx_error_i, rx_active_i, rx_data_valid_i} <= {i[2:0], 1'h1};
            stall <= i[1:0];
            repeat (2) @(posedge clk_i);
            check_flag("data strobe", i[0] & ~i[1], rx_nxt_o);
            settle_check();
        end
        $display("test receive events done");
        set_ctrl(11'h00C);
        {rx_active_i, rx_error_i, disc_i} <= 3'h0;
        for (int b = 0; b < 3; b++)
        begin
            wb_xfer(1'h1, `URX_OFS_RISE_EN, 32'h0, rd);
            wb_xfer(1'h1, `URX_OFS_FALL_EN, 32'h0, rd);
            ind <= 3'h0;
            repeat (16) @(posedge clk_i);
            base = link_cnt;
            edge_step(b, 1'h1, 0);
            wb_xfer(1'h1, `URX_OFS_RISE_EN, 32'(1 << b), rd);
            edge_step(b, 1'h0, 0);
            edge_step(b, 1'h1, 1);
            wb_xfer(1'h1, `URX_OFS_FALL_EN, 32'(1 << b), rd);
            edge_step(b, 1'h0, 2);
        end
        $display("test indicator enables done");
        give_verdict();
    end
endmodule

// ---- urx_sync.sv ----
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk_i.
`timescale 1ns/1ps
module urx_sync
#(
    parameter int W = 1
)
(
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    // Levels.
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else if (ce_i)
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule
